//--- tlam_monitor.sv
`timescale 1ns/100ps
// Notes on behaviour
// - rw signed thermistor upper threshold, reset zero
// - rw signed thermistor lower threshold, reset zero
// - thresholds compare against raw thermistor code
// - thermistor flags latched, a host write of zero to a flag bit clears it
// - rw alert enable register, reset zero
// - readings valid after twelve millisecond warm-up
// - bit 15 alerts on readings valid
// - charger held off until warm-up ends
// - bit 14 alerts on resistance measurement done
// - bit 11 alerts battery voltage below threshold
// - bit 10 alerts battery voltage above threshold
// - bit 9 alerts input voltage below threshold
// - bit 8 alerts input voltage above threshold
// - bit 7 alerts output voltage below threshold
// - bit 6 alerts output voltage above threshold
// - bits 1,0 gate thermistor high/low alerts
`include "tlam_consts.svh"
module tlam_monitor
    import tlam_pkg::*;
#(
    parameter int WARMUP_CYCLES = `TLAM_WARMUP_CYCLES
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    output logic [15:0] CMD_RDATA,
    output logic CMD_RVALID,
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] NTC_CODE,
    input wire logic [15:0] BATT_CODE,
    input wire logic [15:0] IN_CODE,
    input wire logic [15:0] OUT_CODE,
    input wire logic BSR_DONE,
    output logic TELEM_VALID,
    output logic CHARGER_ENABLE,
    output logic SMBALERT_O,
    output logic SMBALERT_OE
);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    tlam_code_t ntc_upper_threshold_r;
    tlam_code_t ntc_lower_threshold_r;
    tlam_code_t batt_volt_low_threshold_r;
    tlam_code_t batt_volt_high_threshold_r;
    tlam_code_t in_volt_low_threshold_r;
    tlam_code_t in_volt_high_threshold_r;
    tlam_code_t out_volt_low_threshold_r;
    tlam_code_t out_volt_high_threshold_r;
    logic [15:0] limit_alert_enable_r;
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic wr;
    logic rd;

    assign wr = CE && CMD_VALID && CMD_WRITE;
    assign rd = CE && CMD_VALID && !CMD_WRITE;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ntc_upper_threshold_r <= `TLAM_THR_RESET;
            ntc_lower_threshold_r <= `TLAM_THR_RESET;
            batt_volt_low_threshold_r <= `TLAM_THR_RESET;
            batt_volt_high_threshold_r <= `TLAM_THR_RESET;
            in_volt_low_threshold_r <= `TLAM_THR_RESET;
            in_volt_high_threshold_r <= `TLAM_THR_RESET;
            out_volt_low_threshold_r <= `TLAM_THR_RESET;
            out_volt_high_threshold_r <= `TLAM_THR_RESET;
            limit_alert_enable_r <= `TLAM_ENABLE_RESET;
        end else if (wr) begin
            case (CMD_CODE)
                `TLAM_CMD_NTC_UPPER: ntc_upper_threshold_r <= CMD_WDATA;
                `TLAM_CMD_NTC_LOWER: ntc_lower_threshold_r <= CMD_WDATA;
                `TLAM_CMD_BATT_LOW: batt_volt_low_threshold_r <= CMD_WDATA;
                `TLAM_CMD_BATT_HIGH: batt_volt_high_threshold_r <= CMD_WDATA;
                `TLAM_CMD_IN_LOW: in_volt_low_threshold_r <= CMD_WDATA;
                `TLAM_CMD_IN_HIGH: in_volt_high_threshold_r <= CMD_WDATA;
                `TLAM_CMD_OUT_LOW: out_volt_low_threshold_r <= CMD_WDATA;
                `TLAM_CMD_OUT_HIGH: out_volt_high_threshold_r <= CMD_WDATA;
                `TLAM_CMD_ENABLE: limit_alert_enable_r <= CMD_WDATA;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            CMD_RDATA <= 16'h0000;
            CMD_RVALID <= 1'b0;
        end else if (CE) begin
            CMD_RVALID <= rd;
            if (rd) begin
                case (CMD_CODE)
                    `TLAM_CMD_NTC_UPPER: CMD_RDATA <= ntc_upper_threshold_r;
                    `TLAM_CMD_NTC_LOWER: CMD_RDATA <= ntc_lower_threshold_r;
                    `TLAM_CMD_BATT_LOW: CMD_RDATA <= batt_volt_low_threshold_r;
                    `TLAM_CMD_BATT_HIGH: CMD_RDATA <= batt_volt_high_threshold_r;
                    `TLAM_CMD_IN_LOW: CMD_RDATA <= in_volt_low_threshold_r;
                    `TLAM_CMD_IN_HIGH: CMD_RDATA <= in_volt_high_threshold_r;
                    `TLAM_CMD_OUT_LOW: CMD_RDATA <= out_volt_low_threshold_r;
                    `TLAM_CMD_OUT_HIGH: CMD_RDATA <= out_volt_high_threshold_r;
                    `TLAM_CMD_ENABLE: CMD_RDATA <= limit_alert_enable_r;
                    `TLAM_CMD_FLAGS: CMD_RDATA <= flags_r;
                    default: CMD_RDATA <= 16'h0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // warm-up timer
    // ----------------------------------------
    tlam_warm_t warm_r;
    logic [31:0] warm_cnt_r;
    logic telem_rise;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            warm_r <= TLAM_WARMING;
            warm_cnt_r <= 32'h00000000;
        end else if (CE) begin
            case (warm_r)
                TLAM_WARMING: begin
                    if (warm_cnt_r == 32'(WARMUP_CYCLES - 1)) begin
                        warm_r <= TLAM_READY;
                    end else begin
                        warm_cnt_r <= warm_cnt_r + 32'h00000001;
                    end
                end
                TLAM_READY: warm_r <= TLAM_READY;
                default: warm_r <= TLAM_WARMING;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            TELEM_VALID <= 1'b0;
            CHARGER_ENABLE <= 1'b0;
        end else if (CE) begin
            TELEM_VALID <= (warm_r == TLAM_READY);
            CHARGER_ENABLE <= (warm_r == TLAM_READY);
        end
    end

    assign telem_rise = (warm_r == TLAM_READY) && !TELEM_VALID;

    // ----------------------------------------
    // limit compare and flags
    // ----------------------------------------
    logic [15:0] set_vec;
    logic [15:0] clr_keep;
    logic cmp_en;

    assign cmp_en = SAMPLE_VALID && TELEM_VALID;

    always_comb begin
        set_vec = 16'h0000;
        set_vec[`TLAM_BIT_TELEM_VALID] = telem_rise;
        set_vec[`TLAM_BIT_BSR_DONE] = BSR_DONE;
        set_vec[`TLAM_BIT_BATT_LOW] = cmp_en && ($signed(BATT_CODE) < batt_volt_low_threshold_r);
        set_vec[`TLAM_BIT_BATT_HIGH] = cmp_en && ($signed(BATT_CODE) > batt_volt_high_threshold_r);
        set_vec[`TLAM_BIT_IN_LOW] = cmp_en && ($signed(IN_CODE) < in_volt_low_threshold_r);
        set_vec[`TLAM_BIT_IN_HIGH] = cmp_en && ($signed(IN_CODE) > in_volt_high_threshold_r);
        set_vec[`TLAM_BIT_OUT_LOW] = cmp_en && ($signed(OUT_CODE) < out_volt_low_threshold_r);
        set_vec[`TLAM_BIT_OUT_HIGH] = cmp_en && ($signed(OUT_CODE) > out_volt_high_threshold_r);
        set_vec[`TLAM_BIT_NTC_UPPER] = cmp_en && ($signed(NTC_CODE) > ntc_upper_threshold_r);
        set_vec[`TLAM_BIT_NTC_LOWER] = cmp_en && ($signed(NTC_CODE) < ntc_lower_threshold_r);
    end

    // write of zero to a flag bit clears it; a new event wins
    assign clr_keep = (wr && CMD_CODE == `TLAM_CMD_FLAGS) ? CMD_WDATA : 16'hFFFF;
    assign flags_nxt = (flags_r & clr_keep) | set_vec;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            flags_r <= `TLAM_FLAGS_RESET;
        end else if (CE) begin
            flags_r <= flags_nxt;
        end
    end

    // ----------------------------------------
    // alert pin
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            SMBALERT_O <= 1'b0;
            SMBALERT_OE <= 1'b0;
        end else if (CE) begin
            SMBALERT_O <= 1'b0;
            SMBALERT_OE <= |(flags_r & limit_alert_enable_r & 16'hCFC3);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    sequence s_flag_write(int code);
        CE && CMD_VALID && CMD_WRITE && CMD_CODE == code;
    endsequence

    property p_upper_store;
        s_flag_write(`TLAM_CMD_NTC_UPPER) |=> ntc_upper_threshold_r == $past(CMD_WDATA);
    endproperty
    a_upper_store: assert property (p_upper_store) else $error("upper threshold not stored");

    property p_lower_store;
        s_flag_write(`TLAM_CMD_NTC_LOWER) |=> ntc_lower_threshold_r == $past(CMD_WDATA);
    endproperty
    a_lower_store: assert property (p_lower_store) else $error("lower threshold not stored");

    property p_enable_read;
        CE && CMD_VALID && !CMD_WRITE && CMD_CODE == `TLAM_CMD_ENABLE
            |=> CMD_RVALID && CMD_RDATA == $past(limit_alert_enable_r);
    endproperty
    a_enable_read: assert property (p_enable_read) else $error("enable readback wrong");

    property p_ntc_high_set;
        CE && cmp_en && $signed(NTC_CODE) > ntc_upper_threshold_r |=> flags_r[`TLAM_BIT_NTC_UPPER];
    endproperty
    a_ntc_high_set: assert property (p_ntc_high_set) else $error("thermistor high flag missed");

    property p_ntc_clear;
        s_flag_write(`TLAM_CMD_FLAGS) ##0 (!CMD_WDATA[`TLAM_BIT_NTC_LOWER] && !set_vec[`TLAM_BIT_NTC_LOWER])
            |=> !flags_r[`TLAM_BIT_NTC_LOWER];
    endproperty
    a_ntc_clear: assert property (p_ntc_clear) else $error("thermistor low flag not cleared");

    property p_flag_hold;
        CE && flags_r[`TLAM_BIT_BATT_LOW] && !(CMD_VALID && CMD_WRITE) |=> flags_r[`TLAM_BIT_BATT_LOW];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("battery low flag dropped");

    property p_charger_gate;
        CHARGER_ENABLE |-> TELEM_VALID && warm_cnt_r == 32'(WARMUP_CYCLES - 1);
    endproperty
    a_charger_gate: assert property (p_charger_gate) else $error("charger on before warm-up");

    property p_valid_flag;
        CE && telem_rise |=> flags_r[`TLAM_BIT_TELEM_VALID] ##0 TELEM_VALID;
    endproperty
    a_valid_flag: assert property (p_valid_flag) else $error("valid flag not raised");

    property p_alert_drive;
        CE && |(flags_r & limit_alert_enable_r & 16'hCFC3) |=> SMBALERT_OE && !SMBALERT_O;
    endproperty
    a_alert_drive: assert property (p_alert_drive) else $error("alert not driven");

    property p_reserved_quiet;
        CE && (flags_r & limit_alert_enable_r & 16'hCFC3) == 16'h0000 |=> !SMBALERT_OE;
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) else $error("alert without enabled flag");

    property p_bsr_flag;
        CE && BSR_DONE |=> flags_r[`TLAM_BIT_BSR_DONE];
    endproperty
    a_bsr_flag: assert property (p_bsr_flag) else $error("resistance done flag missed");

    sequence s_sample;
        CE && cmp_en;
    endsequence

    property p_batt_low_set;
        s_sample ##0 ($signed(BATT_CODE) < batt_volt_low_threshold_r) |=> flags_r[`TLAM_BIT_BATT_LOW];
    endproperty
    a_batt_low_set: assert property (p_batt_low_set) else $error("battery low flag missed");

    property p_batt_high_set;
        s_sample ##0 ($signed(BATT_CODE) > batt_volt_high_threshold_r) |=> flags_r[`TLAM_BIT_BATT_HIGH];
    endproperty
    a_batt_high_set: assert property (p_batt_high_set) else $error("battery high flag missed");

    property p_in_low_set;
        s_sample ##0 ($signed(IN_CODE) < in_volt_low_threshold_r) |=> flags_r[`TLAM_BIT_IN_LOW];
    endproperty
    a_in_low_set: assert property (p_in_low_set) else $error("input low flag missed");

    property p_in_high_set;
        s_sample ##0 ($signed(IN_CODE) > in_volt_high_threshold_r) |=> flags_r[`TLAM_BIT_IN_HIGH];
    endproperty
    a_in_high_set: assert property (p_in_high_set) else $error("input high flag missed");

    property p_out_low_set;
        s_sample ##0 ($signed(OUT_CODE) < out_volt_low_threshold_r) |=> flags_r[`TLAM_BIT_OUT_LOW];
    endproperty
    a_out_low_set: assert property (p_out_low_set) else $error("output low flag missed");

    property p_out_high_set;
        s_sample ##0 ($signed(OUT_CODE) > out_volt_high_threshold_r) |=> flags_r[`TLAM_BIT_OUT_HIGH];
    endproperty
    a_out_high_set: assert property (p_out_high_set) else $error("output high flag missed");

endmodule

//--- tlam_consts.svh
`ifndef TLAM_CONSTS_SVH
`define TLAM_CONSTS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define TLAM_CMD_BATT_LOW 8'h01
`define TLAM_CMD_BATT_HIGH 8'h02
`define TLAM_CMD_IN_LOW 8'h03
`define TLAM_CMD_IN_HIGH 8'h04
`define TLAM_CMD_OUT_LOW 8'h05
`define TLAM_CMD_OUT_HIGH 8'h06
`define TLAM_CMD_NTC_UPPER 8'h0B
`define TLAM_CMD_NTC_LOWER 8'h0C
`define TLAM_CMD_ENABLE 8'h0D
`define TLAM_CMD_FLAGS 8'h36

// ----------------------------------------
// reset values
// ----------------------------------------
`define TLAM_THR_RESET 16'h0000
`define TLAM_ENABLE_RESET 16'h0000
`define TLAM_FLAGS_RESET 16'h0000

// ----------------------------------------
// bit positions
// ----------------------------------------
`define TLAM_BIT_TELEM_VALID 15
`define TLAM_BIT_BSR_DONE 14
`define TLAM_BIT_BATT_LOW 11
`define TLAM_BIT_BATT_HIGH 10
`define TLAM_BIT_IN_LOW 9
`define TLAM_BIT_IN_HIGH 8
`define TLAM_BIT_OUT_LOW 7
`define TLAM_BIT_OUT_HIGH 6
`define TLAM_BIT_NTC_UPPER 1
`define TLAM_BIT_NTC_LOWER 0

// ----------------------------------------
// timing
// ----------------------------------------
`define TLAM_MCLK_KHZ 200000
`define TLAM_WARMUP_MS 12
`define TLAM_WARMUP_CYCLES (`TLAM_WARMUP_MS * `TLAM_MCLK_KHZ)

`endif

//--- tlam_pkg.sv
package tlam_pkg;
    typedef enum logic [0:0] {
        TLAM_WARMING,
        TLAM_READY
    } tlam_warm_t;
    typedef logic signed [15:0] tlam_code_t;
endpackage

//--- tlam_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host side of the command port and alert wire
// ----------------------------------------
module tlam_host (
    input wire logic mclk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic smbalert_o,
    input wire logic smbalert_oe,
    output logic alert_n
);
    // pulled-up open-drain alert line
    assign alert_n = smbalert_oe ? smbalert_o : 1'b1;

    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = 1'b1;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_wdata = ~d;
    endtask

    // answer is taken one cycle after the request
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        d = 16'hXXXX;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = 1'b0;
        cmd_code = c;
        @(negedge mclk);
        cmd_valid = 1'b0;
        if (cmd_rvalid === 1'b1) begin
            d = cmd_rdata;
        end
    endtask
endmodule

//--- tlam_monitor_tb_top.sv
`timescale 1ns/100ps
`include "tlam_consts.svh"
module tlam_monitor_tb_top
    import tlam_pkg::*;
;
    localparam int WU = 20;
    logic mclk, srst, ce, cmd_valid, cmd_write, cmd_rvalid, sample_valid, bsr_done;
    logic telem_valid, charger_enable, smbalert_o, smbalert_oe, alert_n;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, rd_data;
    tlam_code_t ntc, batt, vin, vout;
    int n_errors, total_checks, n;

    tlam_monitor #(.WARMUP_CYCLES(WU)) tlam_monitor_inst (.MCLK(mclk), .SRST(srst), .CE(ce),
        .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata),
        .CMD_RDATA(cmd_rdata), .CMD_RVALID(cmd_rvalid), .SAMPLE_VALID(sample_valid), .NTC_CODE(ntc),
        .BATT_CODE(batt), .IN_CODE(vin), .OUT_CODE(vout), .BSR_DONE(bsr_done), .TELEM_VALID(telem_valid),
        .CHARGER_ENABLE(charger_enable), .SMBALERT_O(smbalert_o), .SMBALERT_OE(smbalert_oe));
    tlam_host tlam_host_inst (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe), .alert_n(alert_n));

    always #2.5 mclk = ~mclk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] c, input logic [15:0] e);
        tlam_host_inst.rd(c, rd_data);
        chk(nm, e, rd_data);
    endtask

    task automatic samp(input tlam_code_t t, input tlam_code_t b, input tlam_code_t i, input tlam_code_t o);
        @(negedge mclk);
        ntc = t;
        batt = b;
        vin = i;
        vout = o;
        sample_valid = 1'b1;
        @(negedge mclk);
        sample_valid = 1'b0;
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(5 * 3000);
        n_errors++;
        give_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        srst = 1'b1;
        ce = 1'b1;
        sample_valid = 1'b0;
        bsr_done = 1'b0;
        ntc = 16'h0000;
        batt = 16'h0000;
        vin = 16'h0000;
        vout = 16'h0000;
        n_errors = 0;
        total_checks = 0;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        n = 0;
        while (telem_valid !== 1'b1 && n < 100) begin
            chk("charger_off", 16'h0000, {15'h0000, charger_enable});
            @(negedge mclk);
            n++;
        end
        chk("warmup_edges", 16'(WU + 1), n[15:0]);
        chk("charger_on", 16'h0001, {15'h0000, charger_enable});
        repeat (2) @(negedge mclk);
        chk("alert_gated", 16'h0000, {15'h0000, smbalert_oe});
        rchk("upper_rst", `TLAM_CMD_NTC_UPPER, `TLAM_THR_RESET);
        rchk("lower_rst", `TLAM_CMD_NTC_LOWER, `TLAM_THR_RESET);
        rchk("enable_rst", `TLAM_CMD_ENABLE, `TLAM_ENABLE_RESET);
        rchk("unmapped", 8'h50, 16'h0000);
        rchk("flags_warm", `TLAM_CMD_FLAGS, 16'h8000);
        // upper is the cold limit, lower the hot limit
        tlam_host_inst.wr(`TLAM_CMD_NTC_UPPER, 16'h1000);
        tlam_host_inst.wr(`TLAM_CMD_NTC_LOWER, 16'hF000);
        tlam_host_inst.wr(`TLAM_CMD_ENABLE, 16'hFFFF);
        rchk("upper_rw", `TLAM_CMD_NTC_UPPER, 16'h1000);
        rchk("lower_rw", `TLAM_CMD_NTC_LOWER, 16'hF000);
        rchk("enable_rw", `TLAM_CMD_ENABLE, 16'hFFFF);
        chk("alert_warm", 16'h0000, {15'h0000, alert_n});
        samp(16'shF800, 16'sh0000, 16'sh0000, 16'sh0000);
        rchk("flags_inrange", `TLAM_CMD_FLAGS, 16'h8000);
        samp(16'sh1001, 16'shFFFF, 16'shFFFF, 16'shFFFF);
        samp(16'shEFFF, 16'sh0001, 16'sh0001, 16'sh0001);
        @(negedge mclk);
        bsr_done = 1'b1;
        @(negedge mclk);
        bsr_done = 1'b0;
        rchk("flags_all", `TLAM_CMD_FLAGS, 16'hCFC3);
        for (int b = 0; b < 16; b++) begin
            tlam_host_inst.wr(`TLAM_CMD_ENABLE, 16'h0001 << b);
            repeat (2) @(negedge mclk);
            chk("alert_bit", (16'hCFC3 >> b) & 16'h0001, {15'h0000, smbalert_oe});
        end
        tlam_host_inst.wr(`TLAM_CMD_ENABLE, 16'hFFFF);
        tlam_host_inst.wr(`TLAM_CMD_FLAGS, 16'h7FFF);
        rchk("flags_clr15", `TLAM_CMD_FLAGS, 16'h4FC3);
        tlam_host_inst.wr(`TLAM_CMD_FLAGS, 16'h0000);
        rchk("flags_clr", `TLAM_CMD_FLAGS, 16'h0000);
        repeat (2) @(negedge mclk);
        chk("alert_off", 16'h0001, {15'h0000, alert_n});
        ce = 1'b0;
        tlam_host_inst.wr(`TLAM_CMD_ENABLE, 16'h0000);
        ce = 1'b1;
        rchk("enable_frozen", `TLAM_CMD_ENABLE, 16'hFFFF);
        // mid-run reset must clear written state and restart warm-up
        bsr_done = 1'b1;
        @(negedge mclk);
        bsr_done = 1'b0;
        srst = 1'b1;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        chk("charger_rst", 16'h0000, {15'h0000, charger_enable});
        rchk("upper_rst2", `TLAM_CMD_NTC_UPPER, `TLAM_THR_RESET);
        rchk("enable_rst2", `TLAM_CMD_ENABLE, `TLAM_ENABLE_RESET);
        rchk("flags_rst2", `TLAM_CMD_FLAGS, `TLAM_FLAGS_RESET);
        give_verdict();
    end
endmodule
